// ==== core/stop_power_control.sv ====
`timescale 1ns/100ps
module stop_power_control
  import stop_power_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic stop_exec,
  input wire logic debug_enable_bit,
  input wire logic dbg_cmd_valid,
  input wire dbg_cmd_t dbg_cmd,
  output logic dbg_accept,
  output logic dbg_error,
  input wire logic reset_pin_asserted,
  input wire logic irq_pin_asserted,
  input wire logic rtc_irq,
  input wire logic usb_resume_irq,
  input wire logic lvd_irq,
  input wire logic kbi_irq,
  input wire logic sci_irq,
  input wire logic supply_low,
  output logic illegal_opcode_reset,
  output logic por_restart,
  output logic vector_fetch,
  output logic [15:0] vector_addr,
  output logic pin_latch_hold,
  output logic lvd_reset_enable,
  output power_t power
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register file and bus slave.

  ctrl_t ctrl, next_ctrl;
  logic dp_write, next_dp_write;
  logic [7:0] dp_addr, next_dp_addr;
  logic [31:0] next_hrdata;
  logic ack_write;
  pm_state_t state, next_state;
  logic flag, next_flag;
  logic [31:0] status_word;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[STAT_FLAG_BIT] = flag;
    status_word[STAT_STATE_LSB +: 5] = state;
    status_word[STAT_HOLD_BIT] = pin_latch_hold;
    status_word[STAT_LVDR_BIT] = lvd_reset_enable;
    next_ctrl = ctrl;
    ack_write = 1'b0;
    if (dp_write && dp_addr == CTRL_OFFSET)
    begin
      next_ctrl = hwdata[CTRL_WIDTH-1:0];
    end
    if (dp_write && dp_addr == ACK_OFFSET)
    begin
      ack_write = hwdata[ACK_BIT];
    end
    if (state == ST_WAKE)
    begin
      next_ctrl = CTRL_RESET;
    end
    next_dp_write = 1'b0;
    next_dp_addr = dp_addr;
    next_hrdata = hrdata;
    if (hsel && hready && htrans[1])
    begin
      next_dp_write = hwrite;
      next_dp_addr = haddr[7:0];
      next_hrdata = 32'h0000_0000;
      if (!hwrite && haddr[7:0] == CTRL_OFFSET)
      begin
        next_hrdata[CTRL_WIDTH-1:0] = next_ctrl;
      end
      else if (!hwrite && haddr[7:0] == STATUS_OFFSET)
      begin
        next_hrdata = status_word;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= CTRL_RESET;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode sequencer.

  logic go_stop2, regulator_keep;
  ctrl_t snap, next_snap;
  logic snap_dbg, next_snap_dbg;
  logic next_dbg_accept, next_dbg_error, next_illegal, next_por, next_fetch;
  logic [15:0] next_vector;
  logic next_hold, next_lvdr;
  power_t next_power;
  logic wake_int, deep_wake;

  stop_mode_select u_select (
    .ctrl(ctrl),
    .debug_enable_bit(debug_enable_bit),
    .go_stop2(go_stop2),
    .regulator_keep(regulator_keep)
  );

  always_comb
  begin
    next_state = state;
    next_snap = snap;
    next_snap_dbg = snap_dbg;
    next_dbg_accept = 1'b0;
    next_dbg_error = 1'b0;
    next_illegal = 1'b0;
    next_por = 1'b0;
    next_fetch = 1'b0;
    next_vector = vector_addr;
    next_flag = flag;
    next_hold = pin_latch_hold;
    next_lvdr = lvd_reset_enable;
    wake_int = rtc_irq | usb_resume_irq | lvd_irq | irq_pin_asserted | kbi_irq | sci_irq;
    deep_wake = reset_pin_asserted | irq_pin_asserted | (rtc_irq & snap.rtc_int_enable);
    // Clear first so that a wakeup in the same cycle sets the flag again.
    if (ack_write)
    begin
      next_flag = 1'b0;
      next_hold = 1'b0;
    end
    unique case (state)
      ST_RUN:
      begin
        if (stop_exec)
        begin
          if (!ctrl.stop_instruction_enable)
          begin
            next_illegal = 1'b1;
          end
          else
          begin
            next_snap = ctrl;
            next_snap_dbg = debug_enable_bit;
            next_state = go_stop2 ? ST_STOP2 : ST_STOP3;
            if (go_stop2)
            begin
              next_hold = 1'b1;
            end
          end
        end
        else if (dbg_cmd_valid)
        begin
          next_dbg_accept = 1'b1;
          if (dbg_cmd == CMD_BACKGROUND && debug_enable_bit)
          begin
            next_state = ST_BGND;
          end
        end
      end
      ST_STOP3:
      begin
        if (reset_pin_asserted)
        begin
          next_state = ST_RUN;
          next_fetch = 1'b1;
          next_vector = VEC_RESET;
        end
        else if (wake_int)
        begin
          next_state = ST_RUN;
          next_fetch = 1'b1;
          if (rtc_irq)
            next_vector = VEC_RTC;
          else if (usb_resume_irq)
            next_vector = VEC_USB;
          else if (lvd_irq)
            next_vector = VEC_LVD;
          else if (irq_pin_asserted)
            next_vector = VEC_IRQ;
          else if (kbi_irq)
            next_vector = VEC_KBI;
          else
            next_vector = VEC_SCI;
        end
        else if (dbg_cmd_valid && dbg_cmd == CMD_MEM_STATUS)
        begin
          next_dbg_error = 1'b1;
        end
        else if (dbg_cmd_valid && dbg_cmd == CMD_BACKGROUND && snap_dbg)
        begin
          next_dbg_accept = 1'b1;
          next_state = ST_BGND;
        end
      end
      ST_STOP2:
      begin
        if (deep_wake)
        begin
          next_state = ST_WAKE;
          next_flag = 1'b1;
          next_por = 1'b1;
          next_lvdr = 1'b1;
        end
        else if (dbg_cmd_valid && dbg_cmd == CMD_MEM_STATUS)
        begin
          next_dbg_error = 1'b1;
        end
      end
      ST_WAKE:
      begin
        if (!supply_low)
        begin
          next_state = ST_RUN;
          next_fetch = 1'b1;
          next_vector = VEC_RESET;
        end
      end
      ST_BGND:
      begin
        if (dbg_cmd_valid)
        begin
          next_dbg_accept = 1'b1;
          if (dbg_cmd == CMD_GO)
          begin
            next_state = ST_RUN;
          end
        end
      end
    endcase
    // Power and clock controls follow the state being entered.
    next_power = POWER_RESET;
    next_power.usb_power = ctrl.usb_module_enable & ctrl.usb_transceiver_enable;
    next_power.external_oscillator_on = 1'b1;
    if (next_state == ST_WAKE)
    begin
      next_power.periph_clk_en = 1'b0;
    end
    if (next_state == ST_STOP3 || next_state == ST_STOP2)
    begin
      next_power.periph_clk_en = 1'b0;
      next_power.debug_clk_en = next_snap_dbg;
      next_power.ram_standby = 1'b1;
      next_power.rtc_run = next_snap.rtc_prescaler_select != RTC_PS_OFF;
    end
    if (next_state == ST_STOP3)
    begin
      next_power.regulator_full = next_snap_dbg
        | (next_snap.low_voltage_detect_enable & next_snap.low_voltage_detect_stop_enable);
      next_power.clkgen_on = next_snap.internal_ref_stop_enable;
      next_power.clkgen_standby = ~next_snap.internal_ref_stop_enable;
      next_power.external_oscillator_on = next_snap.external_ref_stop_enable
        & (~next_snap.freq_range_high | (next_snap.low_voltage_detect_enable
        & next_snap.low_voltage_detect_stop_enable));
      next_power.usb_power = next_snap.usb_module_enable
        & next_snap.usb_transceiver_enable;
    end
    if (next_state == ST_STOP2)
    begin
      next_power.regulator_full = 1'b0;
      next_power.core_power = 1'b0;
      next_power.clkgen_on = 1'b0;
      next_power.clkgen_standby = 1'b0;
      next_power.external_oscillator_on = 1'b0;
      next_power.usb_power = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= ST_RUN;
      snap <= CTRL_RESET;
      snap_dbg <= 1'b0;
      dbg_accept <= 1'b0;
      dbg_error <= 1'b0;
      illegal_opcode_reset <= 1'b0;
      por_restart <= 1'b0;
      vector_fetch <= 1'b0;
      vector_addr <= VEC_RESET;
      flag <= 1'b0;
      pin_latch_hold <= 1'b0;
      lvd_reset_enable <= 1'b0;
      power <= POWER_RESET;
    end
    else
    begin
      state <= next_state;
      snap <= next_snap;
      snap_dbg <= next_snap_dbg;
      dbg_accept <= next_dbg_accept;
      dbg_error <= next_dbg_error;
      illegal_opcode_reset <= next_illegal;
      por_restart <= next_por;
      vector_fetch <= next_fetch;
      vector_addr <= next_vector;
      flag <= next_flag;
      pin_latch_hold <= next_hold;
      lvd_reset_enable <= next_lvdr;
      power <= next_power;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_run_stop;
    state == ST_RUN && stop_exec;
  endsequence

  property p_illegal;
    s_run_stop and !ctrl.stop_instruction_enable |=> illegal_opcode_reset && state == ST_RUN;
  endproperty
  a_illegal: assert property (p_illegal) else $error("stop without enable did not reset");

  property p_debug_retentive;
    s_run_stop and ctrl.stop_instruction_enable && debug_enable_bit
      |=> state == ST_STOP3 && power.debug_clk_en && power.regulator_full;
  endproperty
  a_debug_retentive: assert property (p_debug_retentive) else $error("debug stop wrong");

  property p_lvd_retentive;
    s_run_stop and ctrl.stop_instruction_enable && ctrl.low_voltage_detect_enable
      && ctrl.low_voltage_detect_stop_enable |=> state == ST_STOP3;
  endproperty
  a_lvd_retentive: assert property (p_lvd_retentive) else $error("lvd stop not retentive");

  property p_stop_error;
    (state == ST_STOP3 || state == ST_STOP2) && !reset_pin_asserted && !wake_int
      && dbg_cmd_valid && dbg_cmd == CMD_MEM_STATUS |=> dbg_error && !dbg_accept;
  endproperty
  a_stop_error: assert property (p_stop_error) else $error("stop status error missing");

  property p_periph_clk;
    state == ST_STOP3 || state == ST_STOP2 |-> !power.periph_clk_en;
  endproperty
  a_periph_clk: assert property (p_periph_clk) else $error("peripheral clock in stop");

  property p_deep_hold;
    state == ST_STOP2 |-> pin_latch_hold && !power.core_power && power.ram_standby;
  endproperty
  a_deep_hold: assert property (p_deep_hold) else $error("deep stop not latched");

  property p_deep_wake;
    state == ST_STOP2 && deep_wake |=> state == ST_WAKE && flag && por_restart;
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("deep wake sequence wrong");

  property p_wake_vector;
    state == ST_WAKE && !supply_low |=> vector_fetch && vector_addr == VEC_RESET
      && ctrl == CTRL_RESET;
  endproperty
  a_wake_vector: assert property (p_wake_vector) else $error("wake vector wrong");

  property p_ack_open;
    ack_write && !(state == ST_STOP2 && deep_wake)
      && !(state == ST_RUN && stop_exec && ctrl.stop_instruction_enable && go_stop2)
      |=> !pin_latch_hold && !flag;
  endproperty
  a_ack_open: assert property (p_ack_open) else $error("acknowledge did not open");

  property p_flag_holds;
    flag && !ack_write |=> flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag dropped");

endmodule

// ==== core/stop_power_pkg.sv ====
package stop_power_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] ACK_OFFSET = 8'h08;

  // Field positions.
  localparam int ACK_BIT = 0;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_STATE_LSB = 1;
  localparam int STAT_HOLD_BIT = 6;
  localparam int STAT_LVDR_BIT = 7;
  localparam int CTRL_WIDTH = 15;

  // Vector words fetched on restart or wakeup.
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_LVD = 16'hfff8;
  localparam logic [15:0] VEC_RTC = 16'hffc4;
  localparam logic [15:0] VEC_IRQ = 16'hfffa;
  localparam logic [15:0] VEC_KBI = 16'hffcc;
  localparam logic [15:0] VEC_SCI = 16'hffd6;
  localparam logic [15:0] VEC_USB = 16'hfff0;

  localparam logic [3:0] RTC_PS_OFF = 4'h0;

  typedef struct packed {
    logic [3:0] rtc_prescaler_select;
    logic rtc_int_enable;
    logic usb_transceiver_enable;
    logic usb_module_enable;
    logic external_ref_clock_enable;
    logic freq_range_high;
    logic external_ref_stop_enable;
    logic internal_ref_stop_enable;
    logic low_voltage_detect_stop_enable;
    logic low_voltage_detect_enable;
    logic partial_powerdown_select;
    logic stop_instruction_enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 15'h0000;

  typedef struct packed {
    logic periph_clk_en;
    logic debug_clk_en;
    logic regulator_full;
    logic core_power;
    logic clkgen_on;
    logic clkgen_standby;
    logic rtc_run;
    logic external_oscillator_on;
    logic usb_power;
    logic ram_standby;
  } power_t;

  localparam power_t POWER_RESET = 10'h3ec;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_STOP3 = 5'h02,
    ST_STOP2 = 5'h04,
    ST_WAKE = 5'h08,
    ST_BGND = 5'h10
  } pm_state_t;

  typedef enum logic [1:0] {
    CMD_MEM_STATUS = 2'h0,
    CMD_BACKGROUND = 2'h1,
    CMD_GO = 2'h2,
    CMD_OTHER = 2'h3
  } dbg_cmd_t;

endpackage

// ==== core/stop_mode_select.sv ====
`timescale 1ns/100ps
module stop_mode_select
  import stop_power_pkg::*;
(
  input wire ctrl_t ctrl,
  input wire logic debug_enable_bit,
  output logic go_stop2,
  output logic regulator_keep
);

  logic lvd_in_stop;

  // Debug or stop-time voltage detection forces the retentive mode.
  always_comb
  begin
    lvd_in_stop = ctrl.low_voltage_detect_enable & ctrl.low_voltage_detect_stop_enable;
    regulator_keep = debug_enable_bit | lvd_in_stop;
    go_stop2 = ctrl.partial_powerdown_select & ~regulator_keep;
  end

endmodule

// ==== verif/cpu_side_model.sv ====
`timescale 1ns/100ps
module cpu_side_model
  import stop_power_pkg::*;
(
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic [6:0] wake,
  output logic dbg_cmd_valid,
  output dbg_cmd_t dbg_cmd
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wake = 7'h0;
    dbg_cmd_valid = 1'b0;
    dbg_cmd = CMD_OTHER;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge hclk);
    end
    if (n == 50)
    begin
      tb_top.n_errors++;
      tb_top.stop_test();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  // Reset and IRQ lines are only ever driven into the device, never used as outputs.
  task automatic set_wake(input logic [6:0] w);
    wake <= w;
  endtask

  task automatic command(input dbg_cmd_t c);
    dbg_cmd_valid <= 1'b1;
    dbg_cmd <= c;
    @(posedge hclk);
    dbg_cmd_valid <= 1'b0;
  endtask

  // Port values and pin peripherals count as restored by the time this is called.
  task automatic acknowledge();
    logic [31:0] rd;
    bus(1'b1, ACK_OFFSET, 32'h1, rd);
  endtask
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
  import stop_power_pkg::*;
();
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, stop_exec, debug_enable_bit;
  logic dbg_cmd_valid, dbg_accept, dbg_error, supply_low, illegal_opcode_reset, por_restart;
  logic vector_fetch, pin_latch_hold, lvd_reset_enable, por_seen;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] wake;
  logic [15:0] vector_addr;
  dbg_cmd_t dbg_cmd;
  power_t power;
  ctrl_t c;
  int n_errors = 0;
  int checks = 0;
  int seed = 32'h96601ae9;
  int m_lvdr = 0;
  logic [15:0] vecq[$] = '{VEC_IRQ, VEC_RTC, VEC_USB, VEC_LVD, VEC_KBI, VEC_SCI, VEC_RTC};

  stop_power_control stop_power_control_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .stop_exec, .debug_enable_bit, .dbg_cmd_valid, .dbg_cmd,
    .dbg_accept, .dbg_error, .reset_pin_asserted(wake[0]), .irq_pin_asserted(wake[1]),
    .rtc_irq(wake[2]), .usb_resume_irq(wake[3]), .lvd_irq(wake[4]), .kbi_irq(wake[5]),
    .sci_irq(wake[6]), .supply_low, .illegal_opcode_reset, .por_restart, .vector_fetch,
    .vector_addr, .pin_latch_hold, .lvd_reset_enable, .power
  );

  cpu_side_model cpu_side_model_i (
    .hclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .wake,
    .dbg_cmd_valid, .dbg_cmd
  );

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [31:0] st(input int s, input int f, input int h);
    return {24'h0, m_lvdr[0], h[0], s[4:0], f[0]};
  endfunction

  function automatic power_t exp_power(input ctrl_t cc, input logic d, input logic deep);
    power_t p;
    p = '0;
    p.debug_clk_en = d;
    p.regulator_full = d | (cc.low_voltage_detect_enable & cc.low_voltage_detect_stop_enable);
    p.core_power = ~deep;
    p.clkgen_on = ~deep & cc.internal_ref_stop_enable;
    p.clkgen_standby = ~deep & ~cc.internal_ref_stop_enable;
    p.rtc_run = cc.rtc_prescaler_select != RTC_PS_OFF;
    p.external_oscillator_on = ~deep & cc.external_ref_stop_enable
      & (~cc.freq_range_high | (cc.low_voltage_detect_enable & cc.low_voltage_detect_stop_enable));
    p.usb_power = ~deep & cc.usb_module_enable & cc.usb_transceiver_enable;
    p.ram_standby = 1'b1;
    return p;
  endfunction

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    cpu_side_model_i.bus(1'b0, a, 32'h0, rd);
    check(what, exp, rd);
    check("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu_side_model_i.bus(1'b1, a, d, rd);
  endtask

  task automatic enter_stop(input ctrl_t cc, input logic d);
    wr(CTRL_OFFSET, 32'(cc));
    debug_enable_bit <= d;
    stop_exec <= 1'b1;
    @(posedge hclk);
    stop_exec <= 1'b0;
    debug_enable_bit <= ~d;
    @(posedge hclk);
  endtask

  task automatic wait_vec(input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge hclk);
    while (vector_fetch !== 1'b1 && n < 20)
    begin
      por_seen |= por_restart;
      n++;
      @(posedge hclk);
    end
    check("vector_fetch", 32'h1, 32'(vector_fetch));
    check("vector_addr", 32'(exp), 32'(vector_addr));
    if (n == 20)
      stop_test();
  endtask

  task automatic dbg(input dbg_cmd_t cmd, input logic acc, input logic err);
    logic a;
    logic e;
    a = 1'b0;
    e = 1'b0;
    cpu_side_model_i.command(cmd);
    repeat (4)
    begin
      @(posedge hclk);
      a |= dbg_accept;
      e |= dbg_error;
    end
    check("dbg_accept", 32'(acc), 32'(a));
    check("dbg_error", 32'(err), 32'(e));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic deep;
    logic [9:0] m;
    hresetn = 1'b0;
    stop_exec = 1'b0;
    debug_enable_bit = 1'b0;
    supply_low = 1'b0;
    por_seen = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("power", 32'(POWER_RESET), 32'(power));
    check("vector_addr", 32'(VEC_RESET), 32'(vector_addr));
    wr(8'h0c, 32'hffffffff);
    wr(STATUS_OFFSET, 32'hff);
    wr(ACK_OFFSET, 32'h1);
    rd_chk("ctrl", CTRL_OFFSET, 32'h0);
    rd_chk("status", STATUS_OFFSET, st(1, 0, 0));
    rd_chk("ack", ACK_OFFSET, 32'h0);
    rd_chk("unmapped", 8'h0c, 32'h0);
    $display("done registers");
    c = '0;
    enter_stop(c, 1'b0);
    check("illegal_opcode_reset", 32'h1, 32'(illegal_opcode_reset));
    check("power", 32'(POWER_RESET), 32'(power));
    rd_chk("status", STATUS_OFFSET, st(1, 0, 0));
    $display("done illegal stop");
    for (int k = 0; k < 16; k++)
    begin
      c = ctrl_t'(15'($random(seed)));
      c.stop_instruction_enable = 1'b1;
      c.partial_powerdown_select = k[3];
      c.low_voltage_detect_enable = k[1];
      c.low_voltage_detect_stop_enable = k[2];
      c.rtc_int_enable = k[1];
      deep = !k[0] && !(k[1] && k[2]) && k[3];
      m = 10'h3ff;
      enter_stop(c, k[0]);
      check("power", 32'(exp_power(c, k[0], deep) & m), 32'(power & m));
      // Control rewritten in stop must not move the outputs chosen at entry.
      wr(CTRL_OFFSET, 32'(~c));
      repeat (2) @(posedge hclk);
      check("power", 32'(exp_power(c, k[0], deep) & m), 32'(power & m));
      rd_chk("status", STATUS_OFFSET, st(deep ? 4 : 2, 0, deep));
      por_seen = 1'b0;
      if (deep)
      begin
        cpu_side_model_i.set_wake(c.rtc_int_enable ? 7'h78 : 7'h7c);
        repeat (4) @(posedge hclk);
        rd_chk("status", STATUS_OFFSET, st(4, 0, 1));
        cpu_side_model_i.set_wake(c.rtc_int_enable ? 7'h04 : 7'h02);
        if (k == 8)
        begin
          supply_low <= 1'b1;
          for (int i = 0; i < 10; i++)
          begin
            @(posedge hclk);
            por_seen |= por_restart;
            check("vector_fetch", 32'h0, 32'(vector_fetch));
          end
          supply_low <= 1'b0;
        end
      end
      else
        cpu_side_model_i.set_wake(7'h01);
      wait_vec(VEC_RESET);
      cpu_side_model_i.set_wake(7'h00);
      check("por_restart", 32'(deep), 32'(por_seen));
      if (deep)
      begin
        m_lvdr = 1;
        check("lvd_reset_enable", 32'h1, 32'(lvd_reset_enable));
        rd_chk("ctrl", CTRL_OFFSET, 32'h0);
        rd_chk("status", STATUS_OFFSET, st(1, 1, 1));
        cpu_side_model_i.acknowledge();
        @(posedge hclk);
        check("pin_latch_hold", 32'h0, 32'(pin_latch_hold));
      end
      rd_chk("status", STATUS_OFFSET, st(1, 0, 0));
    end
    $display("done stop modes");
    for (int j = 1; j < 8; j++)
    begin
      c = '0;
      c.stop_instruction_enable = 1'b1;
      c.external_ref_clock_enable = 1'b1;
      c.external_ref_stop_enable = 1'b1;
      enter_stop(c, 1'b0);
      cpu_side_model_i.set_wake(j < 7 ? 7'(1 << j) : 7'h7e);
      wait_vec(vecq[j - 1]);
      cpu_side_model_i.set_wake(7'h00);
      rd_chk("status", STATUS_OFFSET, st(1, 0, 0));
    end
    $display("done wake sources");
    dbg(CMD_OTHER, 1'b1, 1'b0);
    c = '0;
    c.stop_instruction_enable = 1'b1;
    c.partial_powerdown_select = 1'b1;
    enter_stop(c, 1'b1);
    rd_chk("status", STATUS_OFFSET, st(2, 0, 0));
    dbg(CMD_MEM_STATUS, 1'b0, 1'b1);
    dbg(CMD_GO, 1'b0, 1'b0);
    dbg(CMD_BACKGROUND, 1'b1, 1'b0);
    rd_chk("status", STATUS_OFFSET, st(16, 0, 0));
    dbg(CMD_MEM_STATUS, 1'b1, 1'b0);
    dbg(CMD_GO, 1'b1, 1'b0);
    rd_chk("status", STATUS_OFFSET, st(1, 0, 0));
    $display("done debug");
    stop_test();
  end
endmodule
